//--- include/sldc_pkg.sv
// Functional notes
// - Frame divider ratio D equals frame_clock_divider_sel plus one, 1 to 8.
// - Frame frequency is source clock over K times N times D.
// - Prescaler ratio N is 16, 64, 128 up to 4096 by prescaler_tap_sel.
// - K is 8 for static, half and quarter duty.
// - K is 6 for third duty, raising frame rate by a third.
// - drive_time_sel sets driver on-time after each voltage transition.
// - Driver on-time never exceeds half a prescaled clock period unless max_drive_force is set.
// - Static duty or blanking forces on-time to half a prescaled period.
// - New drive_time_sel takes effect at once; software blanks first.
// - Codes 0 to 6 give 300,70,150,450,575,850,1150 us; 7 half period.
// - max_drive_force keeps drivers enabled continuously.
// - contrast_level_sel selects 2.60 V to 3.35 V in sixteen steps.
// - New contrast_level_sel is applied only at the next frame start.
// - A segment memory bit at one energizes that segment on its common.
// - Unused segment memory bits are plain read/write storage.
// - Five bytes per common, four commons; bit k of byte j is segment 8j+k.
// - Segment memory bytes are read/write and reset to zero.
// - prescaler_tap_sel picks the tap that with the divider forms the display clock.
// - duty_sel codes 00,01,10,11 select static, half, third, quarter duty.
// - display_blank grounds all lines after the current frame completes.
package sldc_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_FRAME_RATE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_A     = 8'h04;
  localparam logic [7:0] ADDR_DRV_CONTR  = 8'h08;
  localparam logic [7:0] ADDR_STATUS     = 8'h0C;
  localparam logic [7:0] ADDR_SEG_BASE   = 8'h40;
  localparam int         SEG_BYTES       = 20;
  localparam int         BYTES_PER_COM   = 5;
  // ==========================================================================
  // Field positions
  localparam int FR_DIV_LSB  = 0;
  localparam int FR_TAP_LSB  = 4;
  localparam int CA_BLANK    = 0;
  localparam int CA_DUTY_LSB = 4;
  localparam int DC_CC_LSB   = 0;
  localparam int DC_MDT      = 4;
  localparam int DC_DT_LSB   = 5;
  localparam int ST_BLANKED  = 4;
  localparam int ST_COM_LSB  = 5;
  localparam int ST_POL      = 7;
  localparam int ST_MV_LSB   = 16;
  // ==========================================================================
  // Reset values and encodings
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {DUTY_STATIC, DUTY_HALF, DUTY_THIRD, DUTY_QUARTER} sldc_duty_e;
  localparam logic [2:0] DT_HALF_CODE = 3'h7;
  localparam logic [3:0] K_THIRD      = 4'h6;
  localparam logic [3:0] K_OTHER      = 4'h8;
  localparam logic [15:0] TAP_BASE    = 16'h0010;
  localparam logic [15:0] TAP_STEP    = 16'h0020;
  localparam logic [11:0] MV_BASE     = 12'hA28;
  localparam logic [11:0] MV_STEP     = 12'h032;
  // ==========================================================================
  // Drive times
  localparam int CLK_MHZ = 100;
  localparam int DT0_US = 300;
  localparam int DT1_US = 70;
  localparam int DT2_US = 150;
  localparam int DT3_US = 450;
  localparam int DT4_US = 575;
  localparam int DT5_US = 850;
  localparam int DT6_US = 1150;
  localparam logic [6:0][16:0] DRV_CYC_DEF = {17'(DT6_US * CLK_MHZ), 17'(DT5_US * CLK_MHZ),
    17'(DT4_US * CLK_MHZ), 17'(DT3_US * CLK_MHZ), 17'(DT2_US * CLK_MHZ), 17'(DT1_US * CLK_MHZ),
    17'(DT0_US * CLK_MHZ)};
  // ==========================================================================
  // Shared arithmetic
  function automatic logic [15:0] sldc_period(input logic [2:0] tap, input logic [2:0] div);
    logic [15:0] n;
    n = (tap == 3'h0) ? TAP_BASE : 16'(TAP_STEP << tap);
    return 16'(n * ({13'h0, div} + 16'h0001));
  endfunction : sldc_period

  function automatic logic [3:0] sldc_k(input logic [1:0] duty);
    return (duty == DUTY_THIRD) ? K_THIRD : K_OTHER;
  endfunction : sldc_k
endpackage : sldc_pkg

//--- include/sldc_frame_if.sv
`timescale 1ns/1ns
interface sldc_frame_if;
  logic [2:0]  tap_sel;
  logic [2:0]  div_sel;
  logic [1:0]  duty_sel;
  logic [15:0] cnt;
  logic [15:0] period;
  logic        tick;
  logic [2:0]  phase;
  logic        frame_start;
  modport timer (input tap_sel, div_sel, duty_sel, output cnt, period, tick, phase, frame_start);
  modport ctrl  (output tap_sel, div_sel, duty_sel, input cnt, period, tick, phase, frame_start);
endinterface : sldc_frame_if

//--- src/sldc_frame_timer.sv
`timescale 1ns/1ns
module sldc_frame_timer (
  input wire logic aclk,
  input wire logic aresetn,
  sldc_frame_if.timer fi
);
  import sldc_pkg::*;
  logic [3:0] kk;
  logic       wrap;

  // ==========================================================================
  // Fused prescaler and divider: one prescaled clock period is N*D cycles.
  assign fi.period = sldc_period(fi.tap_sel, fi.div_sel);
  assign kk        = sldc_k(fi.duty_sel);
  // A shrinking period must not strand the counter above its new limit.
  assign fi.tick   = (fi.cnt >= fi.period - 16'h0001);
  assign wrap      = ({1'b0, fi.phase} >= kk - 4'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn) fi.cnt <= '0;
    else if (fi.tick) fi.cnt <= '0;
    else fi.cnt <= fi.cnt + 16'h0001;
  end

  // ==========================================================================
  // A frame holds K prescaled periods.
  always_ff @(posedge aclk) begin
    if (!aresetn) fi.phase <= '0;
    else if (fi.tick && wrap) fi.phase <= '0;
    else if (fi.tick) fi.phase <= fi.phase + 3'h1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) fi.frame_start <= 1'b0;
    else fi.frame_start <= fi.tick && wrap;
  end
endmodule : sldc_frame_timer

//--- src/sldc_top.sv
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module sldc_top #(
  parameter logic [6:0][16:0] DRIVE_CYC = sldc_pkg::DRV_CYC_DEF
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [3:0]       common_line,
  output logic [39:0]      segment_line,
  output logic             line_polarity,
  output logic             drivers_enable,
  output logic [3:0]       max_drive_voltage,
  output logic             frame_start
);
  import sldc_pkg::*;

  // ==========================================================================
  // Declarations
  sldc_frame_if fi ();

  logic [2:0]  prescaler_tap_sel;
  logic [2:0]  frame_clock_divider_sel;
  logic        display_blank;
  logic [1:0]  duty_sel;
  logic [2:0]  drive_time_sel;
  logic        max_drive_force;
  logic [3:0]  contrast_level_sel;
  logic [7:0]  seg_mem [SEG_BYTES];
  logic        blanked;

  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic        w_strb0;
  logic        do_write;
  logic        wr_ok;
  logic [31:0] rd_word;
  logic        rd_ok;

  logic [1:0]  com_idx;
  logic [15:0] half_period;
  logic [16:0] drv_limit;
  logic        next_drivers_enable;
  logic [39:0] next_segment_line;
  logic [3:0]  next_common_line;

  // ==========================================================================
  // Address decode shared by both channels
  function automatic logic seg_hit(input logic [7:0] a);
    return (a >= ADDR_SEG_BASE) && (a < ADDR_SEG_BASE + 8'(4 * SEG_BYTES)) && (a[1:0] == 2'h0);
  endfunction : seg_hit

  function automatic logic [4:0] seg_idx(input logic [7:0] a);
    logic [7:0] off;
    off = a - ADDR_SEG_BASE;
    return off[6:2];
  endfunction : seg_idx

  function automatic logic reg_hit(input logic [7:0] a);
    return (a == ADDR_FRAME_RATE) || (a == ADDR_CTRL_A) || (a == ADDR_DRV_CONTR) ||
           (a == ADDR_STATUS) || seg_hit(a);
  endfunction : reg_hit

  // ==========================================================================
  // Frame timer
  assign fi.tap_sel  = prescaler_tap_sel;
  assign fi.div_sel  = frame_clock_divider_sel;
  assign fi.duty_sel = duty_sel;

  sldc_frame_timer u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fi      (fi)
  );

  assign frame_start = fi.frame_start;

  // ==========================================================================
  // AXI4-Lite write channel
  // Address and data are caught separately so either may arrive first.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign wr_ok         = reg_hit(aw_addr) && (aw_addr != ADDR_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held  <= 1'b0;
      w_data  <= '0;
      w_strb0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held  <= 1'b1;
      w_data  <= s_axi_wdata;
      w_strb0 <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Control registers
  // All writable registers are one byte wide, so only byte lane 0 carries data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescaler_tap_sel       <= RST_BYTE[2:0];
      frame_clock_divider_sel <= RST_BYTE[2:0];
    end else if (do_write && w_strb0 && aw_addr == ADDR_FRAME_RATE) begin
      prescaler_tap_sel       <= w_data[FR_TAP_LSB +: 3];
      frame_clock_divider_sel <= w_data[FR_DIV_LSB +: 3];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      display_blank <= RST_BYTE[0];
      duty_sel      <= RST_BYTE[1:0];
    end else if (do_write && w_strb0 && aw_addr == ADDR_CTRL_A) begin
      display_blank <= w_data[CA_BLANK];
      duty_sel      <= w_data[CA_DUTY_LSB +: 2];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_time_sel     <= RST_BYTE[2:0];
      max_drive_force    <= RST_BYTE[0];
      contrast_level_sel <= RST_BYTE[3:0];
    end else if (do_write && w_strb0 && aw_addr == ADDR_DRV_CONTR) begin
      drive_time_sel     <= w_data[DC_DT_LSB +: 3];
      max_drive_force    <= w_data[DC_MDT];
      contrast_level_sel <= w_data[DC_CC_LSB +: 4];
    end
  end

  // ==========================================================================
  // Segment memory
  // Bytes for commons or segments the glass lacks stay ordinary storage.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < SEG_BYTES; i++) begin
        seg_mem[i] <= RST_BYTE;
      end
    end else if (do_write && w_strb0 && seg_hit(aw_addr)) begin
      seg_mem[seg_idx(aw_addr)] <= w_data[7:0];
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  always_comb begin
    rd_word = '0;
    rd_ok   = reg_hit(s_axi_araddr);
    case (s_axi_araddr)
      ADDR_FRAME_RATE: begin
        rd_word[FR_TAP_LSB +: 3] = prescaler_tap_sel;
        rd_word[FR_DIV_LSB +: 3] = frame_clock_divider_sel;
      end
      ADDR_CTRL_A: begin
        rd_word[CA_BLANK]        = display_blank;
        rd_word[CA_DUTY_LSB +: 2] = duty_sel;
      end
      ADDR_DRV_CONTR: begin
        rd_word[DC_DT_LSB +: 3] = drive_time_sel;
        rd_word[DC_MDT]         = max_drive_force;
        rd_word[DC_CC_LSB +: 4] = contrast_level_sel;
      end
      ADDR_STATUS: begin
        rd_word[DC_CC_LSB +: 4]  = max_drive_voltage;
        rd_word[ST_BLANKED]      = blanked;
        rd_word[ST_COM_LSB +: 2] = com_idx;
        rd_word[ST_POL]          = line_polarity;
        rd_word[ST_MV_LSB +: 12] = 12'(MV_BASE + MV_STEP * {8'h0, max_drive_voltage});
      end
      default: begin
        if (seg_hit(s_axi_araddr)) begin
          rd_word[7:0] = seg_mem[seg_idx(s_axi_araddr)];
        end
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Frame-synchronous state
  // Blanking and contrast wait for the frame boundary so no frame is cut.
  always_ff @(posedge aclk) begin
    if (!aresetn) blanked <= 1'b0;
    else if (fi.frame_start) blanked <= display_blank;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) max_drive_voltage <= RST_BYTE[3:0];
    else if (fi.frame_start) max_drive_voltage <= contrast_level_sel;
  end

  // ==========================================================================
  // Common sequencing
  // In third and quarter duty each common gets a pair of periods of opposite polarity; half duty gives each two pairs.
  always_comb begin
    case (duty_sel)
      DUTY_STATIC: com_idx = 2'h0;
      DUTY_HALF:   com_idx = {1'b0, fi.phase[2]};
      DUTY_THIRD:  com_idx = fi.phase[2:1];
      DUTY_QUARTER: com_idx = fi.phase[2:1];
      default:     com_idx = 2'h0;
    endcase
  end

  always_comb begin
    next_segment_line = '0;
    next_common_line  = '0;
    if (!blanked) begin
      for (int j = 0; j < BYTES_PER_COM; j++) begin
        next_segment_line[8 * j +: 8] = seg_mem[int'(com_idx) * BYTES_PER_COM + j];
      end
      next_common_line[com_idx] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      segment_line  <= '0;
      common_line   <= '0;
      line_polarity <= 1'b0;
    end else begin
      segment_line  <= next_segment_line;
      common_line   <= next_common_line;
      line_polarity <= fi.phase[0] && !blanked;
    end
  end

  // ==========================================================================
  // Drive-time gating
  // The period counter doubles as time since the last voltage transition.
  // drive_time_sel is used live, so changing it mid-frame may glitch.
  assign half_period = fi.period >> 1;

  always_comb begin
    if (duty_sel == DUTY_STATIC || blanked || drive_time_sel == DT_HALF_CODE) begin
      drv_limit = {1'b0, half_period};
    end else if (DRIVE_CYC[drive_time_sel] > {1'b0, half_period}) begin
      drv_limit = {1'b0, half_period};
    end else begin
      drv_limit = DRIVE_CYC[drive_time_sel];
    end
    next_drivers_enable = max_drive_force || ({1'b0, fi.cnt} < drv_limit);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) drivers_enable <= 1'b0;
    else drivers_enable <= next_drivers_enable;
  end
endmodule : sldc_top

//--- tb/sldc_top_properties.sv
`timescale 1ns/1ns
// ==========================================================================
// Port-level properties of the display controller
module sldc_checker #(
  parameter logic [6:0][16:0] DRIVE_CYC = sldc_pkg::DRV_CYC_DEF
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [3:0]  common_line,
  input wire logic [39:0] segment_line,
  input wire logic        line_polarity,
  input wire logic [3:0]  max_drive_voltage,
  input wire logic        frame_start
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_frame_pulse_single: assert property (
    frame_start |=> !frame_start) else $error("frame_start held longer than one cycle");
  a_contrast_frame_sync: assert property (
    $changed(max_drive_voltage) |-> frame_start || $past(frame_start)) else $error("contrast moved mid-frame");
  a_common_one_hot: assert property (
    $onehot0(common_line)) else $error("more than one common line active");
  a_blank_lines_low: assert property (
    common_line == 4'h0 |-> segment_line == 40'h0 && !line_polarity) else $error("lines not grounded");
  a_write_resp_time: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_resp_time: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read response late");
  a_bresp_held_stable: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_held_stable: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_busy_write_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while response pending");
endmodule : sldc_checker

bind sldc_top sldc_checker #(.DRIVE_CYC(DRIVE_CYC)) sldc_checker_inst (.*);

//--- tb/sldc_glass_model.sv
`timescale 1ns/1ns
// ==========================================================================
// Passive glass
module sldc_glass_model (
  input wire logic             aclk,
  input wire logic [3:0]       common_line,
  input wire logic [39:0]      segment_line,
  input wire logic             drivers_enable,
  output logic     [3:0][39:0] lit
);
  // A segment only takes a new state while its common is selected and the drivers are on.
  always_ff @(posedge aclk) begin
    for (int c = 0; c < 4; c++) begin
      if (common_line[c] && drivers_enable) begin
        lit[c] <= segment_line;
      end
    end
  end
endmodule : sldc_glass_model

//--- tb/sldc_top_tb_top.sv
`timescale 1ns/1ns
module sldc_top_tb_top;
  import sldc_pkg::*;
  // Short drive times so every code stays below half of a 16-cycle period.
  localparam logic [6:0][16:0] DCYC = {17'h00007, 17'h00006, 17'h00005, 17'h00004, 17'h00002, 17'h00001, 17'h00003};
  logic             aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]       s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0]       s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0]      s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]       s_axi_wstrb = 4'hF, common_line, max_drive_voltage;
  logic             s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic             s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic             s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]       s_axi_bresp, s_axi_rresp;
  logic [39:0]      segment_line;
  logic             line_polarity, drivers_enable, frame_start;
  logic [3:0][39:0] lit;
  logic [7:0]       mem [int];
  logic [31:0]      lfsr = 32'h000185CE;
  int               miscompares = 0, total_checks = 0;

  sldc_top #(.DRIVE_CYC(DCYC)) sldc_top_inst (.*);
  sldc_glass_model sldc_glass_model_inst (.*);

  always #5 aclk = ~aclk;

  // ==========================================================================
  // Reporting
  task automatic finish_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      miscompares++;
      finish_test();
    end
  endtask : bound

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic [39:0] seg_exp(input int c);
    logic [39:0] e;
    for (int j = 0; j < BYTES_PER_COM; j++) e[8*j +: 8] = mem[8'(ADDR_SEG_BASE + 4 * (c * BYTES_PER_COM + j))];
    return e;
  endfunction : seg_exp

  // ==========================================================================
  // Register bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    bound(n, 50);
    s_axi_bready <= 1'b0;
    check("bresp", s_axi_bresp, er);
    if (er == RESP_OKAY && s_axi_wstrb[0]) mem[a] = d[7:0];
    // One edge passes so the next call never re-raises a ready in the same step.
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    bound(n, 50);
    s_axi_rready <= 1'b0;
    check("rresp", s_axi_rresp, er);
    check("rdata", s_axi_rdata, (er == RESP_OKAY && mem.exists(a)) ? mem[a] : 8'h00);
    @(posedge aclk);
  endtask : rd

  // ==========================================================================
  // Display timing
  task automatic wait_fs();
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (frame_start !== 1'b1 && n < 40000);
    bound(n, 40000);
  endtask : wait_fs

  // The frame holding a setting change is mixed, so counting starts at the next boundary.
  task automatic gap_check(input int exp);
    int c;
    wait_fs();
    c = 0;
    do begin
      @(posedge aclk);
      c++;
    end while (frame_start !== 1'b1 && c < 40000);
    bound(c, 40000);
    check("frame gap", c, exp);
  endtask : gap_check

  // Any window of one frame holds exactly K prescaled periods, so alignment does not matter.
  task automatic drv_check(input int exp);
    int h;
    h = 0;
    wait_fs();
    wait_fs();
    repeat (128) begin
      @(posedge aclk);
      h += (drivers_enable === 1'b1);
    end
    check("drive cycles", h, exp);
  endtask : drv_check

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    mem.delete();
  endtask : do_reset

  initial begin
    do_reset();
    for (int i = 0; i < 23; i++) rd(i < 3 ? 8'(4 * i) : 8'(ADDR_SEG_BASE + 4 * (i - 3)), RESP_OKAY);
    for (int i = 0; i < SEG_BYTES; i++) begin
      lfsr = lfsr_next(lfsr);
      wr(8'(ADDR_SEG_BASE + 4 * i), lfsr, RESP_OKAY);
    end
    for (int i = 0; i < SEG_BYTES; i++) rd(8'(ADDR_SEG_BASE + 4 * i), RESP_OKAY);
    s_axi_wstrb <= 4'hE;
    wr(ADDR_SEG_BASE, 32'h000000FF, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(ADDR_SEG_BASE, RESP_OKAY);
    rd(8'h10, RESP_SLVERR);
    rd(8'h90, RESP_SLVERR);
    wr(8'h10, 32'h000000A5, RESP_SLVERR);
    wr(ADDR_STATUS, 32'h0000005A, RESP_SLVERR);
    wr(ADDR_FRAME_RATE, 32'h0, RESP_OKAY);
    wr(ADDR_CTRL_A, 32'h30, RESP_OKAY);
    wr(ADDR_DRV_CONTR, 32'h0, RESP_OKAY);
    repeat (3) wait_fs();
    for (int c = 0; c < 4; c++) check("glass", lit[c], seg_exp(c));
    wait_fs();
    wr(ADDR_DRV_CONTR, 32'h0B, RESP_OKAY);
    check("contrast held", max_drive_voltage, 4'h0);
    wait_fs();
    @(posedge aclk);
    check("contrast applied", max_drive_voltage, 4'hB);
    rd(ADDR_DRV_CONTR, RESP_OKAY);
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_DRV_CONTR, 32'(k * 32 + 11), RESP_OKAY);
      drv_check(8 * ((k == 7) ? 8 : ((DCYC[k] < 8) ? int'(DCYC[k]) : 8)));
    end
    wr(ADDR_DRV_CONTR, 32'h1B, RESP_OKAY);
    drv_check(128);
    wr(ADDR_DRV_CONTR, 32'h2B, RESP_OKAY);
    wr(ADDR_CTRL_A, 32'h00, RESP_OKAY);
    drv_check(64);
    wr(ADDR_CTRL_A, 32'h31, RESP_OKAY);
    drv_check(64);
    check("blank common", common_line, 4'h0);
    check("blank segment", segment_line, 40'h0);
    check("blank polarity", line_polarity, 40'h0);
    wr(ADDR_CTRL_A, 32'h10, RESP_OKAY);
    for (int d = 0; d < 8; d++) begin
      wr(ADDR_FRAME_RATE, 32'(d), RESP_OKAY);
      gap_check(8 * 16 * (d + 1));
    end
    do_reset();
    wr(ADDR_CTRL_A, 32'h20, RESP_OKAY);
    for (int t = 0; t < 6; t++) begin
      wr(ADDR_FRAME_RATE, 32'(t * 16 + 1), RESP_OKAY);
      gap_check(6 * ((t == 0) ? 16 : (32 << t)) * 2);
    end
    finish_test();
  end
endmodule : sldc_top_tb_top
